// file: pbci_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Host control device: APB master for command and query accesses
// ==========================================================================
module pbci_host_model (
  // Clock
  input wire logic pclk,
  // APB master side
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus from time zero
  initial begin
    {paddr, psel, penable, pwrite, pwdata} = '0;
  end
  // One access, held until pready is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    {paddr, pwrite, pwdata, psel, penable} <= {a, w, d, 2'b10};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    // Released data is scrambled so nothing leans on a stale word
    {psel, penable, pwdata} <= {2'b00, ~d};
  endtask
endmodule // pbci_host_model
`default_nettype wire

// file: pbci_mover.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Plunger mover: steps the position counter toward a target
// ==========================================================================
module pbci_mover
  import pbci_pkg::*;
#(
  parameter int unsigned STEP_CYC = STEP_CYCLES  // Cycles per step
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Requests
  input wire logic start,
  input wire logic load,
  input wire logic [POS_W-1:0] target,
  // State
  output logic [POS_W-1:0] pos,
  output logic moving
);

  // Divider must fit its counter
  if (STEP_CYC < 1 || STEP_CYC > 65535) begin : g_chk
    $error("step cycle count out of range");
  end

  typedef struct packed {
    logic [POS_W-1:0] pos;  // Position counter
    logic [POS_W-1:0] tgt;  // Current target
    logic [15:0] div;       // Step divider
    logic moving;           // Move in progress
  } pbci_mv_s;

  pbci_mv_s s_q;
  pbci_mv_s s_d;
  localparam logic [15:0] DIV_LAST = 16'(STEP_CYC - 1);

  // Next state
  always_comb begin
    s_d = s_q;
    if (load) begin  // Resync overrides any move
      s_d.pos = target;
      s_d.moving = 1'b0;
      s_d.div = '0;
    end else if (start) begin
      s_d.tgt = target;
      s_d.moving = (target != s_q.pos);
      s_d.div = '0;
    end else if (s_q.moving) begin
      if (s_q.div == DIV_LAST) begin  // One step per divider period
        s_d.div = '0;
        s_d.pos = (s_q.tgt > s_q.pos) ? s_q.pos + 1'b1 : s_q.pos - 1'b1;
        s_d.moving = (s_d.pos != s_q.tgt);
      end else begin
        s_d.div = s_q.div + 16'h0001;
      end
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign pos = s_q.pos;
  assign moving = s_q.moving;

  // ========================================================================
  // Checks
  // ========================================================================
  a_move_ends: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    (s_q.moving && !load && !start && s_q.div == DIV_LAST && s_d.pos == s_q.tgt)
    |=> !s_q.moving) else $error("move did not end at target");
  a_step_unit: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    ($past(s_q.moving) && !$past(load) && !$past(start) && $changed(s_q.pos))
    |-> (s_q.pos == $past(s_q.pos) + 1'b1 || s_q.pos == $past(s_q.pos) - 1'b1))
    else $error("plunger jumped more than a step");

endmodule // pbci_mover
`default_nettype wire

// file: pbci_pkg.sv
// ==========================================================================
// Shared constants for the pump command interpreter
// ==========================================================================
package pbci_pkg;

  // ========================================================================
  // Timing
  // ========================================================================
  localparam int unsigned CLK_PERIOD_NS = 100;  // pclk period
  localparam int unsigned STEP_TIME_NS = 1000;  // Least time per plunger step
  // Least time, so rounded up to whole cycles
  localparam int unsigned STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ========================================================================
  // Register byte offsets
  // ========================================================================
  localparam logic [7:0] ADDR_CTRL = 8'h00;      // Execute strobes, mode
  localparam logic [7:0] ADDR_CMD = 8'h04;       // Append one command entry
  localparam logic [7:0] ADDR_STATUS = 8'h08;    // Query answer, error clear
  localparam logic [7:0] ADDR_POS = 8'h0C;       // Plunger position counter
  localparam logic [7:0] ADDR_ENC = 8'h10;       // Synchronised encoder reading
  localparam logic [7:0] ADDR_HOME = 8'h14;      // Homing force and speed
  localparam logic [7:0] ADDR_VALVE_EN = 8'h18;  // Re-enable valve drive
  localparam logic [7:0] ADDR_LEVEL = 8'h1C;     // Buffer fill and exec pointer

  // ========================================================================
  // Field positions
  // ========================================================================
  localparam int unsigned CTRL_RESUME_BIT = 0;   // Run from first unexecuted
  localparam int unsigned CTRL_RESTART_BIT = 1;  // Run from first entry
  localparam int unsigned CTRL_HIRES_BIT = 2;    // High resolution mode
  localparam int unsigned CTRL_CLEAR_BIT = 3;    // Empty the buffer
  localparam int unsigned STAT_RUN_BIT = 0;      // Buffer executing
  localparam int unsigned STAT_NOVALVE_BIT = 1;  // Valve commands ignored
  localparam int unsigned STAT_RIGHT_BIT = 2;    // Valve output on the right
  localparam int unsigned STAT_ERR_BIT = 3;      // Sticky error, write 1 clears
  localparam int unsigned STAT_HALF_BIT = 4;     // Homing at half force
  localparam int unsigned STAT_READY_BIT = 5;    // 1 ready, 0 busy
  localparam int unsigned STAT_VIN_BIT = 6;      // Valve at input port
  localparam int unsigned ENT_OP_LSB = 16;       // Entry opcode field
  localparam int unsigned ENT_W = 24;            // Entry width
  localparam int unsigned POS_W = 16;            // Position and parameter width

  // ========================================================================
  // Command letters
  // ========================================================================
  localparam logic [7:0] OP_INIT_RIGHT = 8'h5A;
  localparam logic [7:0] OP_INIT_LEFT = 8'h59;
  localparam logic [7:0] OP_INIT_NOVALVE = 8'h57;
  localparam logic [7:0] OP_RESYNC = 8'h7A;
  localparam logic [7:0] OP_ABS_BUSY = 8'h41;
  localparam logic [7:0] OP_ABS_READY = 8'h61;
  localparam logic [7:0] OP_VALVE_IN = 8'h49;
  localparam logic [7:0] OP_VALVE_OUT = 8'h4F;

  // ========================================================================
  // Limits and reset values
  // ========================================================================
  localparam logic [15:0] POS_MAX_STD = 16'h1770;    // 6,000 steps
  localparam logic [15:0] POS_MAX_HIRES = 16'hBB80;  // 48,000 steps
  localparam logic [15:0] POS_HOME = 16'h0000;       // Home position
  localparam logic [15:0] HOME_FULL = 16'h0000;      // Full force
  localparam logic [15:0] HOME_HALF = 16'h0001;      // Half force
  localparam logic [15:0] SPEED_MIN = 16'h000A;      // Slowest homing code 10
  localparam logic [15:0] SPEED_MAX = 16'h0028;      // Fastest homing code 40

  // Sequencer states
  typedef enum logic [1:0] {
    PBCI_IDLE,
    PBCI_FETCH,
    PBCI_LAUNCH,
    PBCI_WAIT
  } pbci_state_e;

endpackage

// file: pbci_top.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Resume runs from first unexecuted entry
// - Resume with nothing pending does nothing
// - Status queries answer without execute
// - Restart runs buffer from first entry
// - Each restart while idle repeats whole stored string
// - Right init homes, valve output right
// - Left init homes, valve output left
// - Init parameter picks force or speed
// - No-valve init homes, then valve ignored
// - Resync loads counter from encoder
// - Absolute target within mode range
// - Busy move shows status bit5 zero
// - Ready move keeps reporting ready
// - Ready move polarity taken as one
// ==========================================================================
// Command interpreter top: APB slave, buffer, sequencer
// ==========================================================================
module pbci_top
  import pbci_pkg::*;
#(
  parameter int unsigned DEPTH = 16,        // Buffer entries
  parameter int unsigned STEP_CYC = STEP_CYCLES
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Encoder pins
  input wire logic [POS_W-1:0] enc_pos_pin,
  // Pump drive
  output logic [POS_W-1:0] plunger_pos,
  output logic plunger_moving,
  output logic valve_out_right,
  output logic valve_at_input,
  output logic valve_drive_en,
  output logic home_half_force,
  output logic [POS_W-1:0] home_speed,
  output logic pump_ready
);

  localparam int unsigned PTR_W = $clog2(DEPTH);

  // Buffer must be a power of two the pointers can index
  if (DEPTH < 2 || DEPTH > 256 || (1 << PTR_W) != DEPTH) begin : g_chk
    $error("buffer depth must be a power of two from 2 to 256");
  end

  // ========================================================================
  // State
  // ========================================================================
  typedef struct packed {
    pbci_state_e st;                    // Sequencer state
    logic [DEPTH-1:0][ENT_W-1:0] ent;   // Command buffer
    logic [PTR_W:0] cnt;                // Entries stored
    logic [PTR_W:0] ptr;                // Next entry to run
    logic hires;                        // High resolution mode
    logic novalve;                      // Valve commands ignored
    logic right;                        // Valve output side
    logic vin;                          // Valve at input port
    logic half;                         // Homing half force
    logic [POS_W-1:0] speed;            // Homing speed code
    logic err;                          // Sticky error
    logic busy;                         // Busy-status move running
    logic mv_start;                     // Move request pulse
    logic mv_load;                      // Counter load pulse
    logic [POS_W-1:0] mv_tgt;           // Move target or load value
    logic [POS_W-1:0] enc1;             // Encoder sync, first stage
    logic [POS_W-1:0] enc2;             // Encoder sync, second stage
    logic pready;                       // APB answer
    logic pslverr;                      // APB error
    logic [31:0] prdata;                // APB read data
  } pbci_top_s;

  pbci_top_s s_q;
  pbci_top_s s_d;

  // Mover outputs
  logic [POS_W-1:0] mv_pos;
  logic mv_moving;

  // Decode helpers
  logic [ENT_W-1:0] cur_ent;
  logic [7:0] cur_op;
  logic [POS_W-1:0] cur_par;
  logic [POS_W-1:0] pos_limit;
  logic par_ok;
  logic wr_go;
  logic rd_go;
  logic ctrl_wr;
  logic [31:0] stat_w;

  assign cur_ent = s_q.ent[s_q.ptr[PTR_W-1:0]];
  assign cur_op = cur_ent[ENT_OP_LSB +: 8];
  assign cur_par = cur_ent[POS_W-1:0];
  assign pos_limit = s_q.hires ? POS_MAX_HIRES : POS_MAX_STD;
  // Homing code: full, half, or a speed code
  assign par_ok = (cur_par == HOME_FULL) || (cur_par == HOME_HALF) ||
                  (cur_par >= SPEED_MIN && cur_par <= SPEED_MAX);
  // A write completes at the edge where pready is seen high; a read is taken one edge earlier, in the wait state
  assign wr_go = psel && penable && s_q.pready && pwrite;
  assign rd_go = psel && penable && !s_q.pready && !pwrite;
  assign ctrl_wr = wr_go && (paddr == ADDR_CTRL);

  // Query answer, always live whatever the sequencer does
  always_comb begin
    stat_w = '0;
    stat_w[STAT_RUN_BIT] = (s_q.st != PBCI_IDLE);
    stat_w[STAT_NOVALVE_BIT] = s_q.novalve;
    stat_w[STAT_RIGHT_BIT] = s_q.right;
    stat_w[STAT_ERR_BIT] = s_q.err;
    stat_w[STAT_HALF_BIT] = s_q.half;
    stat_w[STAT_READY_BIT] = !s_q.busy;
    stat_w[STAT_VIN_BIT] = s_q.vin;
  end

  // ========================================================================
  // Next-state logic
  // ========================================================================
  always_comb begin
    s_d = s_q;
    s_d.mv_start = 1'b0;
    s_d.mv_load = 1'b0;
    // Encoder pins: two flops; bits sync alone, pins must hold
    s_d.enc1 = enc_pos_pin;
    s_d.enc2 = s_q.enc1;

    // APB: one wait state, then pready for one cycle
    s_d.pready = psel && penable && !s_q.pready;
    s_d.pslverr = 1'b0;
    if (psel && penable && !s_q.pready) begin
      s_d.prdata = '0;
      case (paddr)
        ADDR_CTRL: s_d.prdata[CTRL_HIRES_BIT] = s_q.hires;
        ADDR_CMD, ADDR_VALVE_EN: s_d.prdata = '0;  // Write-only
        ADDR_STATUS: s_d.prdata = stat_w;
        ADDR_POS: s_d.prdata[POS_W-1:0] = mv_pos;
        ADDR_ENC: s_d.prdata[POS_W-1:0] = s_q.enc2;
        ADDR_HOME: s_d.prdata = {15'h0000, s_q.half, s_q.speed};
        ADDR_LEVEL: s_d.prdata = {16'h0000, 8'(s_q.ptr), 8'(s_q.cnt)};
        default: s_d.pslverr = 1'b1;  // Unmapped address
      endcase
    end

    // Register writes
    if (wr_go) begin
      case (paddr)
        ADDR_CTRL: begin
          s_d.hires = pwdata[CTRL_HIRES_BIT];
          if (pwdata[CTRL_CLEAR_BIT] && s_q.st == PBCI_IDLE) begin
            s_d.cnt = '0;
            s_d.ptr = '0;
          end
        end
        ADDR_CMD: begin
          // Stored only; nothing moves until an execute strobe
          if (s_q.st == PBCI_IDLE && s_q.cnt < (PTR_W+1)'(DEPTH)) begin
            s_d.ent[s_q.cnt[PTR_W-1:0]] = pwdata[ENT_W-1:0];
            s_d.cnt = s_q.cnt + 1'b1;
          end else begin
            s_d.err = 1'b1;  // Full, or running
          end
        end
        ADDR_STATUS: begin
          if (pwdata[STAT_ERR_BIT]) begin
            s_d.err = 1'b0;  // Set below wins over this clear
          end
        end
        ADDR_VALVE_EN: begin
          if (pwdata[0]) begin
            s_d.novalve = 1'b0;  // Valve drive back in use
          end
        end
        default: ;
      endcase
    end

    // Sequencer
    case (s_q.st)
      PBCI_IDLE: begin
        s_d.busy = 1'b0;
        if (ctrl_wr && pwdata[CTRL_RESTART_BIT] && s_q.cnt != '0) begin
          s_d.ptr = '0;  // Whole string again
          s_d.st = PBCI_FETCH;
        end else if (ctrl_wr && pwdata[CTRL_RESUME_BIT] && s_q.ptr < s_q.cnt) begin
          s_d.st = PBCI_FETCH;  // Keep pointer
        end
        // Resume with ptr at cnt stays idle
      end
      PBCI_FETCH: begin
        s_d.busy = 1'b0;
        if (s_q.ptr == s_q.cnt) begin
          s_d.st = PBCI_IDLE;
        end else begin
          s_d.ptr = s_q.ptr + 1'b1;
          case (cur_op)
            OP_INIT_RIGHT, OP_INIT_LEFT, OP_INIT_NOVALVE: begin
              if (par_ok) begin
                s_d.half = (cur_par == HOME_HALF);
                s_d.speed = (cur_par >= SPEED_MIN) ? cur_par : '0;
                if (cur_op == OP_INIT_RIGHT) begin
                  s_d.right = 1'b1;
                  s_d.novalve = 1'b0;
                end else if (cur_op == OP_INIT_LEFT) begin
                  s_d.right = 1'b0;
                  s_d.novalve = 1'b0;
                end else begin
                  s_d.novalve = 1'b1;
                end
                s_d.mv_tgt = POS_HOME;  // Home the plunger
                s_d.mv_start = 1'b1;
                s_d.busy = 1'b1;
                s_d.st = PBCI_LAUNCH;
              end else begin
                s_d.err = 1'b1;
              end
            end
            OP_RESYNC: begin
              s_d.mv_tgt = s_q.enc2;
              s_d.mv_load = 1'b1;
            end
            OP_ABS_BUSY, OP_ABS_READY: begin
              if (cur_par <= pos_limit) begin
                s_d.mv_tgt = cur_par;
                s_d.mv_start = 1'b1;
                // Ready variant keeps bit5 at 1
                s_d.busy = (cur_op == OP_ABS_BUSY);
                s_d.st = PBCI_LAUNCH;
              end else begin
                s_d.err = 1'b1;
              end
            end
            OP_VALVE_IN, OP_VALVE_OUT: begin
              if (!s_q.novalve) begin  // Dropped when no valve
                s_d.vin = (cur_op == OP_VALVE_IN);
              end
            end
            default: s_d.err = 1'b1;  // Unknown letter skipped
          endcase
        end
      end
      PBCI_LAUNCH: begin
        s_d.st = PBCI_WAIT;  // Mover takes the request here
      end
      PBCI_WAIT: begin
        if (!mv_moving) begin
          s_d.busy = 1'b0;
          s_d.st = PBCI_FETCH;
        end
      end
      default: s_d.st = PBCI_IDLE;
    endcase
  end

  // ========================================================================
  // State register, frozen while ce is low
  // ========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ========================================================================
  // Plunger mover
  // ========================================================================
  pbci_mover #(
    .STEP_CYC(STEP_CYC)
  ) u_mover (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .start(s_q.mv_start),
    .load(s_q.mv_load),
    .target(s_q.mv_tgt),
    .pos(mv_pos),
    .moving(mv_moving)
  );

  // Outputs, all from flops
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign plunger_pos = mv_pos;
  assign plunger_moving = mv_moving;
  assign valve_out_right = s_q.right;
  assign valve_at_input = s_q.vin;
  assign valve_drive_en = !s_q.novalve;
  assign home_half_force = s_q.half;
  assign home_speed = s_q.speed;
  assign pump_ready = !s_q.busy;

  // ========================================================================
  // Checks
  // ========================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  logic idle_q;
  assign idle_q = (s_q.st == PBCI_IDLE);

  a_resume_ptr: assert property (idle_q && ctrl_wr && !pwdata[CTRL_RESTART_BIT] &&
    pwdata[CTRL_RESUME_BIT] && s_q.ptr < s_q.cnt |=> s_q.st == PBCI_FETCH && $stable(s_q.ptr))
    else $error("resume did not start at pending entry");
  a_resume_noop: assert property (idle_q && ctrl_wr && !pwdata[CTRL_RESTART_BIT] &&
    s_q.ptr == s_q.cnt |=> idle_q && !s_q.mv_start)
    else $error("resume with nothing pending acted");
  a_query_fast: assert property (rd_go
    |=> s_q.pready && s_q.prdata[STAT_RUN_BIT] == ($past(paddr) != ADDR_STATUS ?
    s_q.prdata[STAT_RUN_BIT] : !$past(idle_q)))
    else $error("query not answered in one wait state");
  a_restart_zero: assert property (idle_q && ctrl_wr && pwdata[CTRL_RESTART_BIT] &&
    s_q.cnt != '0 |=> s_q.st == PBCI_FETCH && s_q.ptr == '0)
    else $error("restart did not begin at first entry");
  a_init_side: assert property (s_q.st == PBCI_FETCH && s_q.ptr != s_q.cnt && par_ok &&
    (cur_op == OP_INIT_RIGHT || cur_op == OP_INIT_LEFT) |=> s_q.mv_tgt == POS_HOME &&
    s_q.right == ($past(cur_op) == OP_INIT_RIGHT) ##1 s_q.st == PBCI_WAIT)
    else $error("init did not home with chosen side");
  a_home_mode: assert property (s_q.st == PBCI_FETCH && s_q.ptr != s_q.cnt &&
    (cur_op == OP_INIT_RIGHT || cur_op == OP_INIT_LEFT || cur_op == OP_INIT_NOVALVE) &&
    !par_ok |=> s_q.err && !s_q.mv_start) else $error("bad homing code accepted");
  a_novalve_hold: assert property (s_q.novalve && s_q.st == PBCI_FETCH &&
    s_q.ptr != s_q.cnt && (cur_op == OP_VALVE_IN || cur_op == OP_VALVE_OUT) |=> $stable(s_q.vin))
    else $error("valve moved while in no-valve mode");
  a_resync_load: assert property (s_q.st == PBCI_FETCH && s_q.ptr != s_q.cnt &&
    cur_op == OP_RESYNC |=> s_q.mv_load && s_q.mv_tgt == $past(s_q.enc2) ##1 mv_pos == $past(s_q.mv_tgt))
    else $error("resync did not load encoder value");
  a_abs_range: assert property (s_q.mv_start |-> s_q.mv_tgt <= pos_limit)
    else $error("move target beyond mode range");
  a_busy_bit: assert property (s_q.st == PBCI_FETCH && s_q.ptr != s_q.cnt &&
    cur_op == OP_ABS_BUSY && cur_par <= pos_limit |=> !stat_w[STAT_READY_BIT] ##1 !pump_ready)
    else $error("busy move did not clear bit 5");
  a_ready_keep: assert property (s_q.st == PBCI_FETCH && cur_op == OP_ABS_READY &&
    cur_par <= pos_limit |=> stat_w[STAT_READY_BIT] [*2]) else $error("ready move showed busy");
  a_no_run_idle: assert property (idle_q |-> !s_q.mv_start && !s_q.mv_load)
    else $error("motion while buffer not executing");

  c_resume_run: cover property (idle_q && ctrl_wr && pwdata[CTRL_RESUME_BIT] ##1 !idle_q);
  c_restart_repeat: cover property (idle_q && ctrl_wr && pwdata[CTRL_RESTART_BIT] && s_q.cnt != 0);
  c_busy_move: cover property (s_q.busy && mv_moving);
  c_resync: cover property (s_q.mv_load);

endmodule // pbci_top
`default_nettype wire

// file: pump_basic_command_interpreter_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Bench: table of APB accesses, then hand tests
// ==========================================================================
module pump_basic_command_interpreter_tb;
  import pbci_pkg::*;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] m; int g;} pbci_row_s;
  pbci_row_s rows[$];  // Address, write, data or expected, read mask, gap
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [15:0] enc = 16'h0123;  // Encoder value picked up by resync
  logic ce = 1'b1;  // Clock enable, dropped once mid-move
  wire [15:0] pos_o, spd_o;  // Plunger position, homing speed
  wire [5:0] flg_o;  // Moving, right, input, drive, half, ready
  logic [7:0] paddr;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] pwdata, prdata, rd;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  // Clock, 100 ns period
  always #50 pclk = ~pclk;
  pbci_host_model host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // One cycle per step keeps moves short
  pbci_top #(.STEP_CYC(1)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enc_pos_pin(enc), .plunger_pos(pos_o),
    .plunger_moving(flg_o[5]), .valve_out_right(flg_o[4]), .valve_at_input(flg_o[3]),
    .valve_drive_en(flg_o[2]), .home_half_force(flg_o[1]), .home_speed(spd_o),
    .pump_ready(flg_o[0]));
  // ========================================================================
  // Compare and closing tasks
  // ========================================================================
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, near twice the cycles the tests need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  // ========================================================================
  // Main sequence
  // ========================================================================
  initial begin
    rows = '{
      '{8'h08, 1'b0, 32'h0000_0020, 32'hFFFF_FFFF, 1},
      '{8'h04, 1'b1, 32'h0061_0005, 32'h0000_0000, 1},
      '{8'h0C, 1'b0, 32'h0000_0000, 32'h0000_FFFF, 1},
      '{8'h00, 1'b1, 32'h0000_0001, 32'h0000_0000, 1},
      '{8'h0C, 1'b0, 32'h0000_0005, 32'h0000_FFFF, 40},
      '{8'h00, 1'b1, 32'h0000_0001, 32'h0000_0000, 1},
      '{8'h1C, 1'b0, 32'h0000_0101, 32'h0000_FFFF, 40},
      '{8'h04, 1'b1, 32'h005A_0001, 32'h0000_0000, 1},
      '{8'h00, 1'b1, 32'h0000_0001, 32'h0000_0000, 1},
      '{8'h14, 1'b0, 32'h0001_0000, 32'h0001_FFFF, 40},
      '{8'h08, 1'b0, 32'h0000_0004, 32'h0000_0004, 1},
      '{8'h04, 1'b1, 32'h0059_0014, 32'h0000_0000, 1},
      '{8'h00, 1'b1, 32'h0000_0001, 32'h0000_0000, 1},
      '{8'h14, 1'b0, 32'h0000_0014, 32'h0001_FFFF, 40},
      '{8'h08, 1'b0, 32'h0000_0000, 32'h0000_0004, 1},
      '{8'h04, 1'b1, 32'h0057_0000, 32'h0000_0000, 1},
      '{8'h00, 1'b1, 32'h0000_0001, 32'h0000_0000, 1},
      '{8'h08, 1'b0, 32'h0000_0002, 32'h0000_0002, 40},
      '{8'h04, 1'b1, 32'h0049_0000, 32'h0000_0000, 1},
      '{8'h00, 1'b1, 32'h0000_0001, 32'h0000_0000, 1},
      '{8'h08, 1'b0, 32'h0000_0000, 32'h0000_0040, 40},
      '{8'h04, 1'b1, 32'h007A_0000, 32'h0000_0000, 1},
      '{8'h00, 1'b1, 32'h0000_0001, 32'h0000_0000, 1},
      '{8'h0C, 1'b0, 32'h0000_0123, 32'h0000_FFFF, 40},
      '{8'h04, 1'b1, 32'h0041_1771, 32'h0000_0000, 1},
      '{8'h00, 1'b1, 32'h0000_0001, 32'h0000_0000, 1},
      '{8'h08, 1'b0, 32'h0000_0008, 32'h0000_0008, 40},
      '{8'h08, 1'b1, 32'h0000_0008, 32'h0000_0000, 1},
      '{8'h04, 1'b1, 32'h0041_0064, 32'h0000_0000, 1},
      '{8'h00, 1'b1, 32'h0000_0001, 32'h0000_0000, 1},
      '{8'h08, 1'b0, 32'h0000_0000, 32'h0000_0020, 2},
      '{8'h04, 1'b1, 32'h0061_0200, 32'h0000_0000, 400},
      '{8'h00, 1'b1, 32'h0000_0001, 32'h0000_0000, 1},
      '{8'h08, 1'b0, 32'h0000_0020, 32'h0000_0020, 2},
      '{8'h0C, 1'b0, 32'h0000_0200, 32'h0000_FFFF, 800},
      '{8'h00, 1'b1, 32'h0000_0002, 32'h0000_0000, 1},
      '{8'h08, 1'b0, 32'h0000_0008, 32'h0000_0008, 1500},
      '{8'h0C, 1'b0, 32'h0000_0200, 32'h0000_FFFF, 1},
      '{8'h08, 1'b1, 32'h0000_0008, 32'h0000_0000, 1},
      '{8'h04, 1'b1, 32'h0059_0005, 32'h0000_0000, 1},
      '{8'h04, 1'b1, 32'h0057_0014, 32'h0000_0000, 1},
      '{8'h04, 1'b1, 32'h0041_1771, 32'h0000_0000, 1},
      '{8'h00, 1'b1, 32'h0000_0005, 32'h0000_0000, 1},
      '{8'h08, 1'b0, 32'h0000_000A, 32'h0000_002A, 40},
      '{8'h0C, 1'b0, 32'h0000_1771, 32'h0000_FFFF, 6600},
      '{8'h18, 1'b1, 32'h0000_0001, 32'h0000_0000, 1},
      '{8'h08, 1'b0, 32'h0000_0000, 32'h0000_0002, 1}
    };
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      repeat (rows[i].g) @(posedge pclk);
      host.xfer(rows[i].a, rows[i].w, rows[i].d, rd, err);
      if (!rows[i].w) chk_word(rd & rows[i].m, rows[i].d);
    end
    chk_word({pos_o, spd_o}, 32'h1771_0014);
    chk_word({26'h000_0000, flg_o}, 32'h0000_0005);
    $display("table test done");
    // Unmapped address answers with an error
    host.xfer(8'h20, 1'b0, 32'h0000_0000, rd, err);
    chk_flag(err, 1'b1);
    $display("unmapped test done");
    // Low enable must freeze a move in flight
    host.xfer(8'h04, 1'b1, 32'h0061_0000, rd, err);
    host.xfer(8'h00, 1'b1, 32'h0000_0001, rd, err);
    repeat (50) @(posedge pclk);
    ce <= 1'b0;
    @(posedge pclk) rd = {16'h0000, pos_o};
    repeat (20) @(posedge pclk);
    chk_word({16'h0000, pos_o}, rd);
    ce <= 1'b1;
    $display("enable test done");
    // Reset in mid-run empties buffer and homes counter
    @(posedge pclk) presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    host.xfer(8'h08, 1'b0, 32'h0000_0000, rd, err);
    chk_word(rd, 32'h0000_0020);
    host.xfer(8'h1C, 1'b0, 32'h0000_0000, rd, err);
    chk_word(rd, 32'h0000_0000);
    chk_word({pos_o, spd_o}, 32'h0000_0000);
    chk_word({26'h000_0000, flg_o}, 32'h0000_0005);
    $display("reset test done");
    test_done();
  end
endmodule // pump_basic_command_interpreter_tb
`default_nettype wire
